// ### core/lptmc_regs.vh
`ifndef LPTMC_REGS_VH
`define LPTMC_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LPTMC_CTL0_OFS      8'h0c
`define LPTMC_CTL1_OFS      8'h10
`define LPTMC_CMPV_OFS      8'h14
`define LPTMC_CAR_OFS       8'h18
`define LPTMC_CTL0_RST      32'h0000_0000
`define LPTMC_CTL1_RST      32'h0000_0000
`define LPTMC_CMPV_RST      32'h0000_0000
`define LPTMC_CAR_RST       32'h0000_0001
`define LPTMC_CTL0_MASK     32'h03fe_eedf

// ---------------------------------------------------------------
// Control zero field positions
// ---------------------------------------------------------------
`define LPTMC_DECSEL_BIT    25
`define LPTMC_DECEN_BIT     24
`define LPTMC_CNTSRC_BIT    23
`define LPTMC_SHADOW_BIT    22
`define LPTMC_OPOL_BIT      21
`define LPTMC_OMODE_BIT     20
`define LPTMC_TMO_BIT       19
`define LPTMC_TRGM_HI       18
`define LPTMC_TRGM_LO       17
`define LPTMC_TSRC_HI       15
`define LPTMC_TSRC_LO       13
`define LPTMC_DIV_HI        11
`define LPTMC_DIV_LO        9
`define LPTMC_TRIGGER_GLITCH_FILTER_HI       7
`define LPTMC_TRIGGER_GLITCH_FILTER_LO       6
`define LPTMC_CFLT_HI       4
`define LPTMC_CFLT_LO       3
`define LPTMC_EDGE_HI       2
`define LPTMC_EDGE_LO       1
`define LPTMC_CKSRC_BIT     0

// ---------------------------------------------------------------
// Control one field positions
// ---------------------------------------------------------------
`define LPTMC_HLC_BIT       31
`define LPTMC_ENF_BIT       30
`define LPTMC_CSTART_BIT    2
`define LPTMC_SSTART_BIT    1
`define LPTMC_EN_BIT        0

`endif

// ### core/lptmc_core.v
// How it works
// (RL1) Count source: kernel clock or input zero
// (RL2) Shadowing defers reload/compare to period end
// (RL3) Polarity picks set/clear on matches
// (RL4) Mode zero PWM/single; mode one set
// (RL5) Timeout mode lets triggers restart counter
// (RL6) Trigger mode picks software or edges
// (RL7) Trigger select picks one of eight
// (RL8) Prescaler divides kernel clock by power two
// (RL9) Trigger filter needs 2/4/8 stable periods
// (RL10) Clock filter needs 2/4/8 stable periods
// (RL11) Edge select: rising, falling, both
// (RL12) Decoder mode zero uses edge variant
// (RL13) Decoder mode one may invert inputs
// (RL14) Software avoids edge code 11, 10/dec1
// (RL15) High-level count inverts only for code 01
// (RL16) Both edges need fast internal clock
// (RL17) Config writes only while timer disabled
// (RL18) Continuous start set by software, hardware-cleared
// (RL19) Enable bit turns the timer on
// (RL20) Trigger code 10 means falling edge
// (RL21) Filters restart count on input change
`include "lptmc_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module lptmc_core #(
  parameter CNT_W = 16
) (
  input  wire              i_clk,
  input  wire              i_sys_rst,
  input  wire              i_wr,
  input  wire              i_rd,
  input  wire [7:0]        i_addr,
  input  wire [31:0]       i_wdata,
  output reg  [31:0]       o_rdata,
  input  wire [7:0]        i_trig_src,
  input  wire              i_timer_input_zero,
  input  wire              i_timer_input_one,
  output reg               o_timer_out,
  output reg  [CNT_W-1:0]  o_count,
  output reg               o_in_sel0,
  output reg               o_in_sel1
);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  reg  [31:0]      ctl0_reg;
  reg              enable_reg;
  reg              hlc_reg;
  reg              cstart_reg;
  reg              sstart_reg;
  reg  [CNT_W-1:0] cmp_wr_reg;
  reg  [CNT_W-1:0] car_wr_reg;
  reg  [CNT_W-1:0] cmp_act_reg;
  reg  [CNT_W-1:0] car_act_reg;
  reg  [CNT_W-1:0] cnt_reg;
  reg              running_reg;
  reg              single_reg;
  localparam [31:0] CMPV_RST = `LPTMC_CMPV_RST;
  localparam [31:0] CAR_RST  = `LPTMC_CAR_RST;
  reg  [6:0]       div_reg;
  reg              trig_raw_reg;
  reg              trig_flt_reg;
  reg  [2:0]       trig_cnt_reg;
  reg              trig_prev_reg;
  reg              ck_raw_reg;
  reg              ck_flt_reg;
  reg  [2:0]       ck_cnt_reg;
  reg              ck_prev_reg;
  reg              dec_prev_reg;

  wire       decsel  = ctl0_reg[`LPTMC_DECSEL_BIT];
  wire       decen   = ctl0_reg[`LPTMC_DECEN_BIT];
  wire       cntsrc  = ctl0_reg[`LPTMC_CNTSRC_BIT];
  wire       shadow  = ctl0_reg[`LPTMC_SHADOW_BIT];
  wire       opol    = ctl0_reg[`LPTMC_OPOL_BIT];
  wire       omode   = ctl0_reg[`LPTMC_OMODE_BIT];
  wire       tmo     = ctl0_reg[`LPTMC_TMO_BIT];
  wire [1:0] trgm    = ctl0_reg[`LPTMC_TRGM_HI:`LPTMC_TRGM_LO];
  wire [2:0] tsrc    = ctl0_reg[`LPTMC_TSRC_HI:`LPTMC_TSRC_LO];
  wire [2:0] divsel  = ctl0_reg[`LPTMC_DIV_HI:`LPTMC_DIV_LO];
  wire [1:0] trigger_glitch_filter    = ctl0_reg[`LPTMC_TRIGGER_GLITCH_FILTER_HI:`LPTMC_TRIGGER_GLITCH_FILTER_LO];
  wire [1:0] cflt    = ctl0_reg[`LPTMC_CFLT_HI:`LPTMC_CFLT_LO];
  wire [1:0] edge_s  = ctl0_reg[`LPTMC_EDGE_HI:`LPTMC_EDGE_LO];

  // Count threshold for a filter code, one less than the stable periods needed
  function [2:0] flt_len;
    input [1:0] code;
    begin
      case (code)
        2'h1:    flt_len = 3'h1;
        2'h2:    flt_len = 3'h3;
        default: flt_len = 3'h7;
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // Input conditioning
  // -------------------------------------------------------------
  // (RL13) Decoder one inversion
  // (RL15) High-level count inversion
  wire inv_in  = (decen & decsel | hlc_reg) & (edge_s == 2'h1);
  wire in0     = i_timer_input_zero ^ inv_in;
  wire in1     = i_timer_input_one ^ inv_in;
  // (RL7) Trigger source pick
  wire trig_in = i_trig_src[tsrc];

  // Digital glitch filters on trigger and clock
  wire trig_chg = trig_raw_reg != trig_flt_reg;
  wire ck_chg   = ck_raw_reg != ck_flt_reg;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      trig_raw_reg <= 1'b0;
      trig_flt_reg <= 1'b0;
      trig_cnt_reg <= 3'h0;
      ck_raw_reg   <= 1'b0;
      ck_flt_reg   <= 1'b0;
      ck_cnt_reg   <= 3'h0;
    end else begin
      trig_raw_reg <= trig_in;
      ck_raw_reg   <= in0;
      // (RL9) Trigger stability count
      // (RL21) Restart on change
      if (trigger_glitch_filter == 2'h0 || (trig_chg && trig_cnt_reg == flt_len(trigger_glitch_filter))) begin
        trig_flt_reg <= trig_raw_reg;
        trig_cnt_reg <= 3'h0;
      end else if (trig_chg && trig_raw_reg == trig_in) begin
        trig_cnt_reg <= trig_cnt_reg + 3'h1;
      end else begin
        trig_cnt_reg <= 3'h0;
      end
      // (RL10) Clock stability count
      // (RL21) Restart on change
      if (cflt == 2'h0 || (ck_chg && ck_cnt_reg == flt_len(cflt))) begin
        ck_flt_reg <= ck_raw_reg;
        ck_cnt_reg <= 3'h0;
      end else if (ck_chg && ck_raw_reg == in0) begin
        ck_cnt_reg <= ck_cnt_reg + 3'h1;
      end else begin
        ck_cnt_reg <= 3'h0;
      end
    end
  end

  // Edge detection on filtered signals
  wire trig_rise = trig_flt_reg & ~trig_prev_reg;
  wire trig_fall = ~trig_flt_reg & trig_prev_reg;
  wire ck_rise   = ck_flt_reg & ~ck_prev_reg;
  wire ck_fall   = ~ck_flt_reg & ck_prev_reg;
  // (RL6) Trigger edge choice
  // (RL20) Falling edge code
  wire trig_evt  = (trgm == 2'h1) ? trig_rise :
                   (trgm == 2'h2) ? trig_fall :
                   (trgm == 2'h3) ? (trig_rise | trig_fall) : 1'b0;
  // (RL11) External clock edges
  // (RL12) Decoder zero variants
  wire ext_tick  = (edge_s == 2'h0) ? ck_rise :
                   (edge_s == 2'h1) ? ck_fall :
                   (edge_s == 2'h2) ? (ck_rise | ck_fall) : 1'b0;
  // Decoder: mode one counts rising edges while input one is high; mode zero needs input one to change
  wire dec_tick  = decsel ? (ck_rise & in1) : (ext_tick & (in1 != dec_prev_reg));

  // (RL8) Power-of-two prescale
  wire div_tick  = ((div_reg & ((7'h1 << divsel) - 7'h1)) == 7'h0);
  // (RL1) Count source
  wire src_tick  = decen ? dec_tick :
                   hlc_reg ? (in0 & in1) :
                   cntsrc ? ext_tick : 1'b1;
  wire tick      = src_tick & div_tick;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      trig_prev_reg <= 1'b0;
      ck_prev_reg   <= 1'b0;
      dec_prev_reg  <= 1'b0;
      div_reg       <= 7'h0;
    end else begin
      trig_prev_reg <= trig_flt_reg;
      ck_prev_reg   <= ck_flt_reg;
      dec_prev_reg  <= in1;
      if (!running_reg)
        div_reg <= 7'h0;
      else if (src_tick)
        div_reg <= div_reg + 7'h1;
    end
  end

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------
  wire period_end = running_reg & tick & (cnt_reg == car_act_reg);
  wire start_req  = (cstart_reg | sstart_reg) & ~running_reg;
  wire trig_ok    = (trgm == 2'h0) ? 1'b1 : trig_evt;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctl0_reg    <= `LPTMC_CTL0_RST;
      enable_reg  <= 1'b0;
      hlc_reg     <= 1'b0;
      cstart_reg  <= 1'b0;
      sstart_reg  <= 1'b0;
      cmp_wr_reg  <= CMPV_RST[CNT_W-1:0];
      car_wr_reg  <= CAR_RST[CNT_W-1:0];
      cmp_act_reg <= CMPV_RST[CNT_W-1:0];
      car_act_reg <= CAR_RST[CNT_W-1:0];
    end else begin
      // (RL17) Locked while enabled
      if (i_wr && i_addr == `LPTMC_CTL0_OFS && !enable_reg)
        ctl0_reg <= i_wdata & `LPTMC_CTL0_MASK;
      if (i_wr && i_addr == `LPTMC_CTL1_OFS) begin
        // (RL19) Enable bit
        enable_reg <= i_wdata[`LPTMC_EN_BIT];
        if (!enable_reg)
          hlc_reg <= i_wdata[`LPTMC_HLC_BIT];
      end
      // (RL18) Start set and clear
      if (i_wr && i_addr == `LPTMC_CTL1_OFS && enable_reg &&
          i_wdata[`LPTMC_CSTART_BIT])
        cstart_reg <= 1'b1;
      else if (start_req && trig_ok || !enable_reg)
        cstart_reg <= 1'b0;
      if (i_wr && i_addr == `LPTMC_CTL1_OFS && enable_reg &&
          i_wdata[`LPTMC_SSTART_BIT])
        sstart_reg <= 1'b1;
      else if (start_req && trig_ok || !enable_reg)
        sstart_reg <= 1'b0;
      if (i_wr && i_addr == `LPTMC_CMPV_OFS && enable_reg)
        cmp_wr_reg <= i_wdata[CNT_W-1:0];
      if (i_wr && i_addr == `LPTMC_CAR_OFS && enable_reg)
        car_wr_reg <= i_wdata[CNT_W-1:0];
      // (RL2) Shadow transfer point
      if (!shadow || period_end || !running_reg) begin
        cmp_act_reg <= cmp_wr_reg;
        car_act_reg <= car_wr_reg;
      end
    end
  end

  // -------------------------------------------------------------
  // Counter and output
  // -------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg     <= {CNT_W{1'b0}};
      running_reg <= 1'b0;
      single_reg  <= 1'b0;
      o_timer_out <= 1'b0;
    end else if (!enable_reg) begin
      cnt_reg     <= {CNT_W{1'b0}};
      running_reg <= 1'b0;
      o_timer_out <= opol;
    end else begin
      if (start_req && trig_ok) begin
        running_reg <= 1'b1;
        single_reg  <= sstart_reg & ~cstart_reg;
        cnt_reg     <= {CNT_W{1'b0}};
      // (RL5) Timeout retrigger
      end else if (running_reg && tmo && trgm != 2'h0 && trig_evt) begin
        cnt_reg <= {CNT_W{1'b0}};
      end else if (period_end) begin
        cnt_reg <= {CNT_W{1'b0}};
        // (RL4) Single pulse stops
        if (single_reg)
          running_reg <= 1'b0;
      end else if (running_reg && tick) begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // (RL3) Polarity on matches
      if (running_reg && tick && cnt_reg == cmp_act_reg)
        o_timer_out <= ~opol;
      // (RL4) Set mode holds output
      else if (period_end && !omode)
        o_timer_out <= opol;
    end
  end

  // Mirrors and read data
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_count   <= {CNT_W{1'b0}};
      o_in_sel0 <= 1'b0;
      o_in_sel1 <= 1'b0;
      o_rdata   <= 32'h0;
    end else begin
      o_count   <= cnt_reg;
      o_in_sel0 <= in0;
      o_in_sel1 <= in1;
      if (!i_rd)
        o_rdata <= 32'h0;
      else if (i_addr == `LPTMC_CTL0_OFS)
        o_rdata <= ctl0_reg;
      else if (i_addr == `LPTMC_CTL1_OFS)
        o_rdata <= {hlc_reg, running_reg, 27'h0, cstart_reg, sstart_reg, enable_reg};
      else if (i_addr == `LPTMC_CMPV_OFS)
        o_rdata <= {{(32-CNT_W){1'b0}}, cmp_wr_reg};
      else if (i_addr == `LPTMC_CAR_OFS)
        o_rdata <= {{(32-CNT_W){1'b0}}, car_wr_reg};
      else
        o_rdata <= 32'h0;
    end
  end

endmodule // lptmc_core

`default_nettype wire

// ### tb/lptmc_core_asserts.sv
`include "lptmc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module lptmc_core_asserts #(
  parameter int CNT_W = 16
) (
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [7:0]       i_addr,
  input wire logic [31:0]      i_wdata,
  input wire logic [31:0]      o_rdata,
  input wire logic             i_timer_input_zero,
  input wire logic             o_timer_out,
  input wire logic [CNT_W-1:0] o_count
);
  logic [31:0] c0_reg;
  logic        en_reg, st_reg;
  logic [7:0]  gap_reg;
  logic [3:0]  qt_reg;
  // ----------------------------------------
  // Shadow of programmed state
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      c0_reg  <= 32'h0;
      en_reg  <= 1'b0;
      st_reg  <= 1'b0;
      gap_reg <= 8'h0;
      qt_reg  <= 4'h0;
    end else begin
      if (i_wr && i_addr == 8'h0c && !en_reg) c0_reg <= i_wdata & `LPTMC_CTL0_MASK;
      if (i_wr && i_addr == 8'h10) en_reg <= i_wdata[0];
      st_reg  <= en_reg && (st_reg || $changed(o_count));
      gap_reg <= ($changed(o_count) || !en_reg) ? 8'h0 : gap_reg + {7'h0, gap_reg != 8'hff};
      qt_reg  <= $changed(i_timer_input_zero) ? 4'h0 : qt_reg + {3'h0, qt_reg != 4'hf};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  AST_CTL0_READ: assert property (i_rd && i_addr == 8'h0c |=> o_rdata == $past(c0_reg))
    else $error("control zero readback wrong");
  AST_EN_READ: assert property (i_rd && i_addr == 8'h10 |=> o_rdata[0] == $past(en_reg))
    else $error("enable readback wrong");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not idle");
  AST_STOP_HOLD: assert property (!en_reg [*3] |=> $stable(o_count))
    else $error("counter moved while disabled");
  AST_STEP: assert property (en_reg && !c0_reg[23] && !c0_reg[24] && $changed(o_count)
      |-> o_count == $past(o_count) + 1'b1 || o_count == '0)
    else $error("counter step wrong");
  AST_PSC: assert property (en_reg && st_reg && !c0_reg[23] && !c0_reg[24] && $changed(o_count)
      && o_count != '0 && $past(o_count) != '0
      |-> gap_reg == (8'h1 << c0_reg[11:9]) - 8'h1)
    else $error("prescaled step spacing wrong");
  AST_EXT_QUIET: assert property (en_reg && c0_reg[23] && !c0_reg[24] && c0_reg[18:17] == 2'b00
      && qt_reg == 4'hf |=> $stable(o_count))
    else $error("external count without input edge");
  AST_SET_HOLD: assert property (en_reg && $past(en_reg) && c0_reg[20]
      && $past(o_timer_out) != c0_reg[21] |-> $stable(o_timer_out))
    else $error("set mode output released");
  cover property (en_reg && $rose(o_timer_out));
  cover property (i_wr && i_addr == 8'h0c && en_reg);
  cover property (en_reg && c0_reg[23] && $changed(o_count));
endmodule // lptmc_core_asserts
`default_nettype wire

// ### tb/lptmc_core_test.sv
`include "lptmc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module lptmc_core_test;
  logic        i_clk, i_sys_rst, i_wr, i_rd, i_timer_input_zero, i_timer_input_one;
  logic        o_timer_out, o_in_sel0, o_in_sel1, smp, rd_d, sm_d;
  logic [7:0]  i_addr, i_trig_src, lf;
  logic [31:0] i_wdata, o_rdata, obs, c0;
  logic [15:0] o_count, b;
  logic [63:0] exq[$];
  logic [63:0] e;
  int          error_cnt, samples_checked, k;
  lptmc_core lptmc_core_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_trig_src(i_trig_src),
    .i_timer_input_zero(i_timer_input_zero), .i_timer_input_one(i_timer_input_one),
    .o_timer_out(o_timer_out), .o_count(o_count), .o_in_sel0(o_in_sel0), .o_in_sel1(o_in_sel1));
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    cyc(1);
    i_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    exq.push_back({m, x});
    i_addr = a;
    i_rd = 1'b1;
    cyc(1);
    i_rd = 1'b0;
    cyc(1);
  endtask
  task automatic note(input logic [31:0] g, input logic [31:0] x);
    exq.push_back({32'hffff_ffff, x});
    obs = g;
    smp = 1'b1;
    cyc(1);
    smp = 1'b0;
  endtask
  task automatic wcnt(input logic [15:0] v);
    k = 0;
    while (o_count !== v && k < 4000) begin
      cyc(1);
      k++;
    end
    if (o_count !== v) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, o_count, v);
    end
  endtask
  // Stop, program, enable, load matches, start
  task automatic go(input logic [31:0] c, input logic [1:0] st);
    wr(8'h10, 32'h0);
    wr(8'h0c, c);
    wr(8'h10, 32'h1);
    wr(8'h18, 32'h7);
    wr(8'h14, 32'h3);
    wr(8'h10, {29'h0, st, 1'b1});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Result monitor
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    sm_d <= smp;
  end
  always @(negedge i_clk) begin
    if (rd_d || sm_d) begin
      e = exq.pop_front();
      samples_checked++;
      if (((rd_d ? o_rdata : obs) & e[63:32]) !== e[31:0]) begin
        error_cnt++;
        $display("mismatch at %0t got %h exp %h", $time, rd_d ? o_rdata : obs, e[31:0]);
      end
    end
  end
  // Watchdog
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
  // Main sequence
  initial begin
    {i_sys_rst, i_wr, i_rd, smp, i_timer_input_zero, i_timer_input_one} = 6'h20;
    {i_addr, i_trig_src, i_wdata, obs, lf} = {16'h0, 64'h0, 8'h3f};
    cyc(16);
    i_sys_rst = 1'b0;
    rd(8'h0c, '1, 32'h0);
    rd(8'h10, '1, 32'h0);
    rd(8'h14, '1, 32'h0);
    rd(8'h18, '1, 32'h1);
    rd(8'h20, '1, 32'h0);
    // Edge code kept to 00 or 01, clock source internal
    c0 = {4{lf}} & `LPTMC_CTL0_MASK & 32'hffff_fffa;
    wr(8'h0c, {4{lf}} & 32'hffff_fffa);
    rd(8'h0c, '1, c0);
    wr(8'h10, 32'h1);
    wr(8'h0c, ~c0);
    rd(8'h0c, '1, c0);
    rd(8'h10, 32'h1, 32'h1);
    $display("lock test done");
    for (int p = 0; p < 8; p++) begin
      go(32'(p[0]) << 21 | 32'(p) << 9, 2'b10);
      wcnt(16'h1);
      wcnt(16'h2);
      note(k, 1 << p);
      wcnt(16'h5);
      note(o_timer_out, {31'h0, ~p[0]});
      wcnt(16'h1);
      note(o_timer_out, p[0]);
    end
    go(32'h0010_0000, 2'b10);
    wcnt(16'h5);
    wcnt(16'h1);
    note(o_timer_out, 32'h1);
    go(32'h0, 2'b01);
    cyc(40);
    note(o_timer_out, 32'h0);
    // Shadowed reload written mid-period only lands at period end
    go(32'h0040_0000, 2'b10);
    wcnt(16'h1);
    wr(8'h18, 32'h4);
    wcnt(16'h6);
    note(o_count, 32'h6);
    wcnt(16'h4);
    cyc(1);
    note(o_count, 32'h0);
    $display("output test done");
    for (int c = 0; c < 3; c++) begin
      go(32'h0080_0000 | 32'(c + 1) << 3 | 32'(c) << 1, 2'b10);
      cyc(20);
      b = o_count;
      i_timer_input_zero = 1'b1;
      cyc((2 << c) - 1);
      i_timer_input_zero = 1'b0;
      cyc(20);
      repeat (3) begin
        i_timer_input_zero = 1'b1;
        cyc(16);
        i_timer_input_zero = 1'b0;
        cyc(16);
      end
      note((o_count - b) & 16'h7, c == 2 ? 6 : 3);
    end
    $display("external clock test done");
    for (int m = 1; m < 4; m++) begin
      lf = nx(lf);
      i_trig_src = nx(lf);
      i_trig_src[lf[2:0]] = (m == 2);
      go(32'(m) << 17 | 32'(lf[2:0]) << 13 | 32'(m) << 6, 2'b10);
      i_trig_src[lf[2:0]] = ~i_trig_src[lf[2:0]];
      cyc((1 << m) - 1);
      i_trig_src[lf[2:0]] = ~i_trig_src[lf[2:0]];
      b = o_count;
      cyc(20);
      note(o_count, b);
      i_trig_src[lf[2:0]] = ~i_trig_src[lf[2:0]];
      cyc(20);
      b = o_count;
      cyc(1);
      note((o_count - b) & 16'h7, 32'h1);
    end
    $display("trigger test done");
    {i_timer_input_one, i_timer_input_zero} = lf[1:0];
    for (int j = 0; j < 4; j++) begin
      wr(8'h10, 32'h0);
      wr(8'h0c, 32'(j[0]) << 1 | 32'(j[1]) * 32'h0300_0000);
      wr(8'h10, {~j[1], 30'h0, 1'b1});
      cyc(20);
      note({o_in_sel1, o_in_sel0}, {2{j[0]}} ^ lf[1:0]);
    end
    $display("input select test done");
    cyc(5);
    stop_test();
  end
endmodule // lptmc_core_test
bind lptmc_core lptmc_core_asserts #(.CNT_W(CNT_W)) lptmc_core_asserts_i (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .i_timer_input_zero(i_timer_input_zero), .o_timer_out(o_timer_out),
  .o_count(o_count));
`default_nettype wire
